/* File: verilog/qpb_pkg.sv */
// Shared constants, types and helpers for the quad-pumped data phase
package qpb_pkg;

  localparam int MCLK_NS        = 10;
  localparam int BCLK_PERIOD_NS = 160;
  localparam int DATA_W         = 64;
  localparam int GROUPS         = 4;
  localparam int GROUP_W        = 16;
  localparam int BEATS          = 4;
  localparam int LINE_W         = DATA_W * BEATS;
  localparam int REQ_W          = 4;
  localparam int FIFO_DEPTH     = 8;
  localparam int BCLK_CYC       = BCLK_PERIOD_NS / MCLK_NS;
  localparam int BCLK_HALF_CYC  = BCLK_CYC / 2;
  localparam int BEAT_CYC       = BCLK_CYC / BEATS;
  localparam int STROBE_PHASE   = BEAT_CYC / 2;
  localparam logic [4:0] FLIP_LIMIT = 5'(GROUP_W / 2);
  localparam logic [DATA_W-1:0] DATA_IDLE = {DATA_W{1'b1}};

  typedef enum logic [3:0] {
    QPB_IDLE = 4'b0001,
    QPB_ARB  = 4'b0010,
    QPB_XFER = 4'b0100,
    QPB_REL  = 4'b1000
  } qpb_drv_state_e;

  typedef logic [LINE_W-1:0] qpb_line_t;
  typedef logic [DATA_W-1:0] qpb_word_t;

  // A synchronised level moves only once stages two and three agree
  function automatic logic qpb_agree(input logic s2, input logic s3,
                                     input logic held);
    return (s2 == s3) ? s2 : held;
  endfunction

  function automatic logic [4:0] qpb_ones(input logic [GROUP_W-1:0] v);
    logic [4:0] n;
    n = '0;
    for (int i = 0; i < GROUP_W; i++)
      n = n + {4'h0, v[i]};
    return n;
  endfunction

  function automatic logic [GROUP_W-1:0] qpb_restore(
    input logic [GROUP_W-1:0] pin, input logic invN);
    return invN ? pin : ~pin;
  endfunction

endpackage

/* File: verilog/qpb_fsb_if.sv */
// Front-side bus wires between the processor end and the chipset end
`timescale 1ns/1ps
interface qpb_fsb_if;
  import qpb_pkg::*;

  logic               bus_clock_true;
  logic               bus_clock_complement;
  logic               priority_agent_request_n;
  logic               bnrCpuOe;
  logic               bnrNbOe;
  logic               block_next_request_n;
  logic [REQ_W-1:0]   breqOut;
  logic [REQ_W-1:0]   breqOe;
  logic [REQ_W-1:0]   symmetric_bus_request_n;
  logic               dataOe;
  logic [DATA_W-1:0]  dataOut;
  logic [DATA_W-1:0]  dataBus;
  logic [GROUPS-1:0]  invOut;
  logic [GROUPS-1:0]  group_inverted_n;
  logic [GROUPS-1:0]  evenOut;
  logic [GROUPS-1:0]  even_beat_strobe_n;
  logic [GROUPS-1:0]  oddOut;
  logic [GROUPS-1:0]  odd_beat_strobe_n;
  logic               drdyOut;
  logic               data_valid_n;
  logic               dbsyOut;
  logic               data_bus_in_use_n;

  // Undriven pins float high through their pull-ups
  assign block_next_request_n    = ~(bnrCpuOe | bnrNbOe);
  assign symmetric_bus_request_n = breqOut | ~breqOe;
  assign dataBus                 = dataOe ? dataOut : DATA_IDLE;
  assign group_inverted_n        = dataOe ? invOut : {GROUPS{1'b1}};
  assign even_beat_strobe_n      = dataOe ? evenOut : {GROUPS{1'b1}};
  assign odd_beat_strobe_n       = dataOe ? oddOut : {GROUPS{1'b1}};
  assign data_valid_n            = dataOe ? drdyOut : 1'b1;
  assign data_bus_in_use_n       = dataOe ? dbsyOut : 1'b1;

  modport cpu (
    input  bus_clock_true, bus_clock_complement, priority_agent_request_n,
    input  block_next_request_n, data_bus_in_use_n,
    output bnrCpuOe, breqOut, breqOe, dataOe, dataOut, invOut,
    output evenOut, oddOut, drdyOut, dbsyOut
  );

  modport nb (
    output bus_clock_true, bus_clock_complement, priority_agent_request_n,
    output bnrNbOe,
    input  block_next_request_n, symmetric_bus_request_n, dataBus,
    input  group_inverted_n, even_beat_strobe_n, odd_beat_strobe_n,
    input  data_valid_n, data_bus_in_use_n
  );

endinterface

/* File: verilog/qpb_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides and an occupancy count
`timescale 1ns/1ps
module qpb_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8
) (
  input  wire logic                       mclk,
  input  wire logic                       rst,
  input  wire logic [WIDTH-1:0]           inData,
  input  wire logic                       inValid,
  output logic                            inReady,
  output logic [WIDTH-1:0]                outData,
  output logic                            outValid,
  input  wire logic                       outReady,
  output logic [$clog2(DEPTH+1)-1:0]      count
);
  import qpb_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] memNext [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    wrNext;
  logic [AW-1:0]    rd_reg;
  logic [AW-1:0]    rdNext;
  logic [CW-1:0]    cnt_reg;
  logic [CW-1:0]    cntNext;
  logic             push;
  logic             pop;

  assign inReady  = cnt_reg != CNT_FULL;
  assign outValid = cnt_reg != '0;
  assign outData  = mem_reg[rd_reg];
  assign count    = cnt_reg;

  always_comb
  begin
    push    = inValid && inReady;
    pop     = outValid && outReady;
    memNext = mem_reg;
    wrNext  = wr_reg;
    rdNext  = rd_reg;
    cntNext = cnt_reg;
    if (push)
    begin
      memNext[wr_reg] = inData;
      wrNext = (wr_reg == PTR_LAST) ? '0 : wr_reg + 1'b1;
    end
    if (pop)
      rdNext = (rd_reg == PTR_LAST) ? '0 : rd_reg + 1'b1;
    if (push && !pop)
      cntNext = cnt_reg + 1'b1;
    else if (pop && !push)
      cntNext = cnt_reg - 1'b1;
  end

  // Storage needs no reset; the count alone decides what is valid
  always_ff @(posedge mclk)
  begin
    mem_reg <= memNext;
    if (rst)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      wr_reg  <= wrNext;
      rd_reg  <= rdNext;
      cnt_reg <= cntNext;
    end
  end

endmodule

/* File: verilog/qpb_nb_end.sv */
// Chipset end: bus clock source, priority agent and data receiver
`timescale 1ns/1ps
module qpb_nb_end (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  qpb_fsb_if.nb                     fsb,
  input  wire logic                 priorityReq,
  input  wire logic                 holdOff,
  output qpb_pkg::qpb_word_t        wordData,
  output logic                      wordValid,
  input  wire logic                 wordReady
);
  import qpb_pkg::*;

  localparam int DIV_W   = $clog2(BCLK_HALF_CYC);
  localparam int CTL_W   = 2 * GROUPS + 2;
  localparam int LINK_W  = DATA_W + GROUPS + CTL_W;
  localparam int INV_LO  = DATA_W;
  localparam int CTL_LO  = DATA_W + GROUPS;
  localparam int CNT_W   = $clog2(FIFO_DEPTH + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BCLK_HALF_CYC - 1);
  localparam logic [CNT_W-1:0] ROOM_LIMIT = CNT_W'(FIFO_DEPTH - BEATS);

  logic [DIV_W-1:0]  div_reg;
  logic [DIV_W-1:0]  divNext;
  logic              clk_reg;
  logic              clkNext;
  logic              pri_reg;
  logic              bnr_reg;
  logic              bnrNext;
  logic [LINK_W-1:0] sync1_reg;
  logic [LINK_W-1:0] sync2_reg;
  logic [LINK_W-1:0] sync3_reg;
  logic [CTL_W-1:0]  filt_reg;
  logic [CTL_W-1:0]  filtNext;
  qpb_word_t         word_reg;
  qpb_word_t         wordNext;
  logic [GROUPS-1:0] got_reg;
  logic [GROUPS-1:0] gotNext;
  logic              push_reg;
  logic              pushNext;
  logic              evenFall;
  logic              oddFall;
  logic [CNT_W-1:0]  fill;

  // The chipset is the clock source; the processor samples this pair
  assign fsb.bus_clock_true           = clk_reg;
  assign fsb.bus_clock_complement     = ~clk_reg;
  assign fsb.priority_agent_request_n = ~pri_reg;
  assign fsb.bnrNbOe                  = bnr_reg;

  always_comb
  begin
    divNext = (div_reg == DIV_LAST) ? '0 : div_reg + 1'b1;
    clkNext = (div_reg == DIV_LAST) ? ~clk_reg : clk_reg;
  end

  always_comb
  begin
    filtNext = filt_reg;
    for (int i = 0; i < CTL_W; i++)
      filtNext[i] = qpb_agree(sync2_reg[CTL_LO+i], sync3_reg[CTL_LO+i],
                              filt_reg[i]);
  end

  // Strobe bits in filt: even [G-1:0], odd [2G-1:G], data_valid_n, data_bus_in_use_n on top
  always_comb
  begin
    wordNext = word_reg;
    gotNext  = got_reg;
    pushNext = 1'b0;
    evenFall = 1'b0;
    oddFall  = 1'b0;
    for (int g = 0; g < GROUPS; g++)
    begin
      evenFall = filt_reg[g] & ~filtNext[g];
      oddFall  = filt_reg[GROUPS+g] & ~filtNext[GROUPS+g];
      if ((evenFall || oddFall) && !filt_reg[2*GROUPS])
      begin
        wordNext[g*GROUP_W +: GROUP_W] = qpb_restore(
          sync3_reg[g*GROUP_W +: GROUP_W], sync3_reg[INV_LO+g]);
        gotNext[g] = 1'b1;
      end
    end
    if (&gotNext)
    begin
      pushNext = 1'b1;
      gotNext  = '0;
    end
    // Stall new requests while busy or short of room for a full line
    bnrNext = holdOff || (fill > ROOM_LIMIT)
              || !filt_reg[2*GROUPS+1];
  end

  always_ff @(posedge mclk)
  begin
    sync1_reg <= {fsb.data_bus_in_use_n, fsb.data_valid_n,
                  fsb.odd_beat_strobe_n, fsb.even_beat_strobe_n,
                  fsb.group_inverted_n, fsb.dataBus};
    sync2_reg <= sync1_reg;
    sync3_reg <= sync2_reg;
    if (rst)
    begin
      div_reg  <= '0;
      clk_reg  <= 1'b0;
      pri_reg  <= 1'b0;
      bnr_reg  <= 1'b1;
      filt_reg <= '1;
      word_reg <= '0;
      got_reg  <= '0;
      push_reg <= 1'b0;
    end
    else
    begin
      div_reg  <= divNext;
      clk_reg  <= clkNext;
      pri_reg  <= priorityReq;
      bnr_reg  <= bnrNext;
      filt_reg <= filtNext;
      word_reg <= wordNext;
      got_reg  <= gotNext;
      push_reg <= pushNext;
    end
  end

  // A push into a full FIFO would be lost; the stall above prevents it
  qpb_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) rxFifo (
    .mclk     (mclk),
    .rst      (rst),
    .inData   (word_reg),
    .inValid  (push_reg),
    .inReady  (),
    .outData  (wordData),
    .outValid (wordValid),
    .outReady (wordReady),
    .count    (fill)
  );

endmodule

/* File: verilog/qpb_cpu_end.sv */
// Processor end: drives lines of four quad-pumped beats onto the data bus
// Behaviour
// - bus clock pair from outside times everything
// - stalled agents assert block; requesters then wait
// - priority request comes from chipset, input only
// - processor requests on line zero only
// - data driver marks every beat data-valid
// - four data beats per bus clock
// - receiver latches on falling strobe edges
// - four 16-bit groups, own strobes and flag
// - driver asserts bus-in-use while driving data; code keeps driving data for the QPB_REL cycle after releasing it
// - invert group when over half bits change
// - even strobe even beats, odd strobe odd
`timescale 1ns/1ps
module qpb_cpu_end (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  qpb_fsb_if.cpu                    fsb,
  input  wire qpb_pkg::qpb_line_t   lineData,
  input  wire logic                 lineValid,
  output logic                      lineReady,
  input  wire logic                 holdOff,
  output logic                      busActive
);
  import qpb_pkg::*;

  localparam int LINK_W   = 5;
  localparam int L_TRUE   = 4;
  localparam int L_COMP   = 3;
  localparam int L_BNR    = 2;
  localparam int L_PRI    = 1;
  localparam int L_DATA_BUS_IN_USE_N   = 0;
  localparam int BEAT_W   = $clog2(BEATS);
  localparam int PHASE_W  = $clog2(BEAT_CYC);
  localparam logic [BEAT_W-1:0]  BEAT_LAST  = BEAT_W'(BEATS - 1);
  localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(BEAT_CYC - 1);
  localparam logic [PHASE_W-1:0] PHASE_STB  = PHASE_W'(STROBE_PHASE);

  logic [LINK_W-1:0]  sync1_reg;
  logic [LINK_W-1:0]  sync2_reg;
  logic [LINK_W-1:0]  sync3_reg;
  logic [LINK_W-1:0]  filt_reg;
  logic [LINK_W-1:0]  filtNext;
  logic               clkPrev_reg;
  logic               clkRise;
  logic               busFree;
  qpb_drv_state_e     state_reg;
  qpb_drv_state_e     stateNext;
  qpb_line_t          line_reg;
  qpb_line_t          lineNext;
  logic [BEAT_W-1:0]  beat_reg;
  logic [BEAT_W-1:0]  beatNext;
  logic [BEAT_W-1:0]  beatSel;
  logic [PHASE_W-1:0] phase_reg;
  logic [PHASE_W-1:0] phaseNext;
  logic               loadBeat;
  qpb_word_t          word;
  qpb_word_t          dataPin_reg;
  qpb_word_t          dataNext;
  logic [GROUPS-1:0]  invN_reg;
  logic [GROUPS-1:0]  invNext;
  logic               flip;
  logic               xferNext;
  logic               evenN_reg;
  logic               evenNext;
  logic               oddN_reg;
  logic               oddNext;
  logic               drdyN_reg;
  logic               dbsyN_reg;
  logic               oe_reg;
  logic               oeNext;
  logic               breqN_reg;
  logic               breqNext;
  logic               bnrOe_reg;

  // Same strobe timing on every group; each group still gets its own pair
  assign fsb.dataOut  = dataPin_reg;
  assign fsb.invOut   = invN_reg;
  assign fsb.evenOut  = {GROUPS{evenN_reg}};
  assign fsb.oddOut   = {GROUPS{oddN_reg}};
  assign fsb.drdyOut  = drdyN_reg;
  assign fsb.dbsyOut  = dbsyN_reg;
  assign fsb.dataOe   = oe_reg;
  assign fsb.bnrCpuOe = bnrOe_reg;
  // Lines one to three stay undriven in a single-processor system
  assign fsb.breqOut  = {{(REQ_W-1){1'b1}}, breqN_reg};
  assign fsb.breqOe   = {{(REQ_W-1){1'b0}}, 1'b1};
  assign lineReady    = state_reg == QPB_IDLE;
  assign busActive    = ~dbsyN_reg;

  always_comb
  begin
    filtNext = filt_reg;
    for (int i = 0; i < LINK_W; i++)
      filtNext[i] = qpb_agree(sync2_reg[i], sync3_reg[i], filt_reg[i]);
  end

  // Rising crossing of the pair: true high while complement low
  assign clkRise = filt_reg[L_TRUE] & ~clkPrev_reg
                   & ~filt_reg[L_COMP];
  assign busFree = filt_reg[L_BNR] & filt_reg[L_PRI]
                   & filt_reg[L_DATA_BUS_IN_USE_N];

  always_comb
  begin
    stateNext = state_reg;
    lineNext  = line_reg;
    beatNext  = beat_reg;
    phaseNext = phase_reg;
    beatSel   = beat_reg;
    loadBeat  = 1'b0;
    case (state_reg)
      QPB_IDLE:
        if (lineValid)
        begin
          lineNext  = lineData;
          stateNext = QPB_ARB;
        end
      QPB_ARB:
        if (clkRise && busFree)
        begin
          stateNext = QPB_XFER;
          beatNext  = '0;
          phaseNext = '0;
          beatSel   = '0;
          loadBeat  = 1'b1;
        end
      QPB_XFER:
        if (phase_reg == PHASE_LAST)
        begin
          phaseNext = '0;
          if (beat_reg == BEAT_LAST)
            stateNext = QPB_REL;
          else
          begin
            beatNext = beat_reg + 1'b1;
            beatSel  = beat_reg + 1'b1;
            loadBeat = 1'b1;
          end
        end
        else
          phaseNext = phase_reg + 1'b1;
      QPB_REL:
        stateNext = QPB_IDLE;
      default:
        stateNext = QPB_IDLE;
    endcase
  end

  // Flag a group when flipping it saves toggles against the last pins
  always_comb
  begin
    dataNext = dataPin_reg;
    invNext  = invN_reg;
    word     = line_reg[beatSel*DATA_W +: DATA_W];
    flip     = 1'b0;
    if (loadBeat)
      for (int g = 0; g < GROUPS; g++)
      begin
        flip = qpb_ones(word[g*GROUP_W +: GROUP_W]
                        ^ dataPin_reg[g*GROUP_W +: GROUP_W])
               > FLIP_LIMIT;
        dataNext[g*GROUP_W +: GROUP_W] =
          flip ? ~word[g*GROUP_W +: GROUP_W]
               : word[g*GROUP_W +: GROUP_W];
        invNext[g] = ~flip;
      end
  end

  // Strobes fall mid-beat so data has settled well before the edge
  always_comb
  begin
    xferNext = stateNext == QPB_XFER;
    evenNext = ~(xferNext && !beatNext[0]
                 && phaseNext >= PHASE_STB);
    oddNext  = ~(xferNext && beatNext[0]
                 && phaseNext >= PHASE_STB);
    oeNext   = xferNext || stateNext == QPB_REL;
    breqNext = ~(stateNext == QPB_ARB || xferNext);
  end

  always_ff @(posedge mclk)
  begin
    sync1_reg <= {fsb.bus_clock_true, fsb.bus_clock_complement,
                  fsb.block_next_request_n,
                  fsb.priority_agent_request_n,
                  fsb.data_bus_in_use_n};
    sync2_reg <= sync1_reg;
    sync3_reg <= sync2_reg;
    if (rst)
    begin
      filt_reg    <= '1;
      clkPrev_reg <= 1'b1;
      state_reg   <= QPB_IDLE;
      line_reg    <= '0;
      beat_reg    <= '0;
      phase_reg   <= '0;
      dataPin_reg <= DATA_IDLE;
      invN_reg    <= '1;
      evenN_reg   <= 1'b1;
      oddN_reg    <= 1'b1;
      drdyN_reg   <= 1'b1;
      dbsyN_reg   <= 1'b1;
      oe_reg      <= 1'b0;
      breqN_reg   <= 1'b1;
      bnrOe_reg   <= 1'b0;
    end
    else
    begin
      filt_reg    <= filtNext;
      clkPrev_reg <= filt_reg[L_TRUE];
      state_reg   <= stateNext;
      line_reg    <= lineNext;
      beat_reg    <= beatNext;
      phase_reg   <= phaseNext;
      dataPin_reg <= dataNext;
      invN_reg    <= invNext;
      evenN_reg   <= evenNext;
      oddN_reg    <= oddNext;
      drdyN_reg   <= ~xferNext;
      dbsyN_reg   <= ~xferNext;
      oe_reg      <= oeNext;
      breqN_reg   <= breqNext;
      bnrOe_reg   <= holdOff;
    end
  end

endmodule

/* File: sim/qpb_fsb_chk.sv */
// Concurrent checks on the front-side bus wires between the two ends
`timescale 1ns/1ps
module qpb_fsb_chk (
  input wire logic                       mclk,
  input wire logic                       rst,
  input wire logic                       bus_clock_true,
  input wire logic                       bus_clock_complement,
  input wire logic                       priority_agent_request_n,
  input wire logic                       block_next_request_n,
  input wire logic [qpb_pkg::REQ_W-1:0]  symmetric_bus_request_n,
  input wire logic [qpb_pkg::GROUPS-1:0] group_inverted_n,
  input wire logic [qpb_pkg::GROUPS-1:0] even_beat_strobe_n,
  input wire logic [qpb_pkg::GROUPS-1:0] odd_beat_strobe_n,
  input wire logic                       data_valid_n,
  input wire logic                       data_bus_in_use_n
);
  import qpb_pkg::*;
  logic [4:0] busyLen_reg;
  logic [4:0] busyLen_next;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // Saturates so a stuck bus never wraps back to a legal length
  always_comb
  begin
    busyLen_next = busyLen_reg;
    if (data_bus_in_use_n)
      busyLen_next = 5'h00;
    else if (busyLen_reg != 5'h1f)
      busyLen_next = busyLen_reg + 5'h01;
  end

  always_ff @(posedge mclk)
  begin
    busyLen_reg <= rst ? 5'h00 : busyLen_next;
  end

  a_clock_pair: assert property (
    bus_clock_complement == !bus_clock_true)
    else $error("bus clock pair not complementary");
  a_clock_period: assert property (
    $rose(bus_clock_true) |-> ##16 $rose(bus_clock_true))
    else $error("bus clock period wrong");
  a_stall_blocks: assert property (
    !block_next_request_n [*6] ##1 data_bus_in_use_n |=> data_bus_in_use_n)
    else $error("transfer started during stall");
  a_priority_blocks: assert property (
    !priority_agent_request_n [*6] ##1 data_bus_in_use_n
      |=> data_bus_in_use_n)
    else $error("transfer started under priority request");
  a_req_upper_idle: assert property (
    symmetric_bus_request_n[3:1] == 3'h7)
    else $error("upper request lines driven");
  a_req_while_busy: assert property (
    !data_bus_in_use_n |-> !symmetric_bus_request_n[0])
    else $error("data driven without request line zero");
  a_valid_with_busy: assert property (
    data_valid_n == data_bus_in_use_n)
    else $error("data valid and bus in use disagree");
  a_busy_length: assert property (
    $rose(data_bus_in_use_n) |-> busyLen_reg == 5'h10)
    else $error("bus in use not one bus clock long");
  a_strobe_order: assert property (
    $fell(even_beat_strobe_n[0]) |-> ##4 $fell(odd_beat_strobe_n[0]))
    else $error("odd strobe does not follow even strobe");
  a_first_strobe: assert property (
    $fell(data_bus_in_use_n) |-> ##2 $fell(even_beat_strobe_n[0]))
    else $error("first even strobe misplaced");
  a_busy_stalls: assert property (
    !data_bus_in_use_n [*8] |-> !block_next_request_n)
    else $error("chipset not stalling while bus in use");

  c_transfer: cover property ($rose(data_bus_in_use_n));
  c_inverted: cover property (!data_bus_in_use_n && group_inverted_n != 4'hf);
  c_stalled: cover property (!block_next_request_n && data_bus_in_use_n);
endmodule

/* File: sim/tb_top.sv */
// Self-checking bench: processor end streams lines to the chipset end
`timescale 1ns/1ps
module tb_top;
  import qpb_pkg::*;
  logic        mclk;
  logic        rst;
  qpb_line_t   lineData;
  logic        lineValid;
  logic        lineReady;
  logic        cpuHold;
  logic        nbHold;
  logic        priorityReq;
  logic        stallRx;
  logic        wordReady;
  logic        wordValid;
  qpb_word_t   wordData;
  logic        busActive;
  logic [3:0]  evenPrev;
  logic [3:0]  oddPrev;
  qpb_word_t   lastPin;
  qpb_word_t   outQ[$];
  qpb_word_t   pinQ[$];
  logic [31:0] seed;
  int          beat;
  int          cycles;
  int          failures;
  int          checks;

  qpb_fsb_if fsb();
  qpb_cpu_end i_qpb_cpu_end (.mclk(mclk), .rst(rst), .fsb(fsb.cpu),
    .lineData(lineData), .lineValid(lineValid), .lineReady(lineReady),
    .holdOff(cpuHold), .busActive(busActive));
  qpb_nb_end i_qpb_nb_end (.mclk(mclk), .rst(rst), .fsb(fsb.nb),
    .priorityReq(priorityReq), .holdOff(nbHold), .wordData(wordData),
    .wordValid(wordValid), .wordReady(wordReady));
  qpb_fsb_chk i_qpb_fsb_chk (.mclk(mclk), .rst(rst),
    .bus_clock_true(fsb.bus_clock_true),
    .bus_clock_complement(fsb.bus_clock_complement),
    .priority_agent_request_n(fsb.priority_agent_request_n),
    .block_next_request_n(fsb.block_next_request_n),
    .symmetric_bus_request_n(fsb.symmetric_bus_request_n),
    .group_inverted_n(fsb.group_inverted_n),
    .even_beat_strobe_n(fsb.even_beat_strobe_n),
    .odd_beat_strobe_n(fsb.odd_beat_strobe_n),
    .data_valid_n(fsb.data_valid_n),
    .data_bus_in_use_n(fsb.data_bus_in_use_n));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic qpb_line_t rline();
    qpb_line_t l;
    for (int i = 0; i < 8; i++)
      l[32*i +: 32] = rnd();
    return l;
  endfunction

  function automatic int flips(input logic [15:0] v);
    int n;
    n = 0;
    for (int i = 0; i < 16; i++)
      n = n + int'(v[i]);
    return n;
  endfunction

  task automatic check(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Leaves lineValid high so back-to-back lines need no idle cycle
  task automatic sendLine(input qpb_line_t l);
    int n;
    n = 0;
    lineData <= l;
    lineValid <= 1'b1;
    @(posedge mclk);
    while (lineReady !== 1'b1 && n < 400)
    begin
      @(posedge mclk);
      n++;
    end
    for (int k = 0; k < BEATS; k++)
    begin
      outQ.push_back(l[64*k +: 64]);
      pinQ.push_back(l[64*k +: 64]);
    end
  endtask

  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    lineValid <= 1'b0;
    repeat (n)
    begin
      @(posedge mclk);
      seen = seen | busActive;
    end
    check("stalled start", 0, seen);
  endtask

  task automatic drain();
    lineValid <= 1'b0;
    repeat (800)
      if (outQ.size() + pinQ.size() != 0)
        @(posedge mclk);
    check("left over words", 0, outQ.size() + pinQ.size());
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Decodes the wire on each strobe fall the way a receiver would
  always @(posedge mclk)
  begin
    logic      fe;
    logic      fo;
    int        f;
    qpb_word_t w;
    fe = evenPrev[0] & !fsb.even_beat_strobe_n[0];
    fo = oddPrev[0] & !fsb.odd_beat_strobe_n[0];
    evenPrev <= fsb.even_beat_strobe_n;
    oddPrev <= fsb.odd_beat_strobe_n;
    if (fsb.data_bus_in_use_n !== 1'b0)
      beat = 0;
    if (!rst && (fe || fo))
    begin
      for (int g = 0; g < GROUPS; g++)
      begin
        w[16*g +: 16] = fsb.group_inverted_n[g] ? fsb.dataBus[16*g +: 16]
                                                : ~fsb.dataBus[16*g +: 16];
        f = flips(w[16*g +: 16] ^ lastPin[16*g +: 16]);
        check("inversion flag", f <= 8, fsb.group_inverted_n[g]);
      end
      check("even strobe beat", beat % 2 == 0, fe);
      check("data valid pin", 0, fsb.data_valid_n);
      check("bus in use pin", 0, fsb.data_bus_in_use_n);
      check("cpu busy flag", 1, busActive);
      check("wire word", pinQ.size() ? pinQ.pop_front() : 'x, w);
      lastPin = fsb.dataBus;
      beat++;
    end
  end

  always @(posedge mclk)
  begin
    cycles++;
    if (!rst && wordValid === 1'b1 && wordReady === 1'b1)
      check("word", outQ.size() ? outQ.pop_front() : 'x, wordData);
    wordReady <= !stallRx && (rnd() % 4 != 0);
    if (cycles > 30000)
    begin
      failures++;
      results();
    end
  end

  initial
  begin
    rst = 1'b1;
    lineData = '0;
    lineValid = 1'b0;
    cpuHold = 1'b0;
    nbHold = 1'b0;
    priorityReq = 1'b0;
    stallRx = 1'b0;
    wordReady = 1'b0;
    evenPrev = 4'hf;
    oddPrev = 4'hf;
    lastPin = '1;
    seed = 32'he77a;
    beat = 0;
    cycles = 0;
    failures = 0;
    checks = 0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    // All-zero and all-one words force inversion both ways
    sendLine({64'h0, {64{1'b1}}, 64'h00ff_0f0f_ff00_0001, 64'h0});
    sendLine({64'h01ff_00ff_7fff_8000, {64{1'b1}}, 64'h0,
              64'h5555_5555_aaaa_aaaa});
    repeat (20) sendLine(rline());
    drain();
    // Receiver stalls: FIFO fills and the third line must wait
    stallRx <= 1'b1;
    repeat (3) sendLine(rline());
    repeat (3) @(posedge mclk);
    quiet(120);
    check("fifo holds words", 1, wordValid);
    stallRx <= 1'b0;
    drain();
    for (int s = 0; s < 3; s++)
    begin
      nbHold <= (s == 0);
      priorityReq <= (s == 1);
      cpuHold <= (s == 2);
      repeat (8) @(posedge mclk);
      sendLine(rline());
      quiet(80);
      if (s != 1)
        check("block pin", 0, fsb.block_next_request_n);
      else
        check("priority pin", 0, fsb.priority_agent_request_n);
      nbHold <= 1'b0;
      priorityReq <= 1'b0;
      cpuHold <= 1'b0;
      drain();
    end
    results();
  end
endmodule
